// [icu_top.sv]
// Status, interrupt mask and preview setup registers of the image capture unit
`timescale 1ns/10ps
`include "icu_defs.svh"
module icu_top (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Sensor pins
    input wire logic sensor_pclk,
    input wire logic sensor_vsync,
    // Datapath and DMA status
    input wire icu_pkg::icu_fifo_t fifo,
    input wire logic sync_code_error,
    input wire logic [31:0] desc_current,
    input wire logic desc_current_valid,
    // Datapath control
    output icu_pkg::icu_prev_t preview,
    output logic [31:0] desc_base,
    output logic desc_load,
    output logic frame_discard,
    output logic codec_active,
    output logic codec_capture_done,
    output logic soft_reset,
    // Interrupt
    output logic irq
);
    import icu_pkg::*;

    // ************************************************************
    // Register bus
    // ************************************************************
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic [31:0] rd_word;
    logic rd_hit;
    logic wr_hit;
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire rd_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `ICU_OFF_CTRL || a == `ICU_OFF_STATUS || a == `ICU_OFF_IRQ_EN_SET ||
               a == `ICU_OFF_IRQ_EN_CLR || a == `ICU_OFF_IRQ_MASK || a == `ICU_OFF_PSIZE ||
               a == `ICU_OFF_PDECF || a == `ICU_OFF_PDESC;
    endfunction

    wire [31:0] wr_val = merge(32'h0, w_data, w_strb);
    wire wr_ctrl = wr_fire && aw_addr == `ICU_OFF_CTRL;
    wire wr_status = wr_fire && aw_addr == `ICU_OFF_STATUS;
    wire wr_en_set = wr_fire && aw_addr == `ICU_OFF_IRQ_EN_SET;
    wire wr_en_clr = wr_fire && aw_addr == `ICU_OFF_IRQ_EN_CLR;
    wire wr_psize = wr_fire && aw_addr == `ICU_OFF_PSIZE;
    wire wr_pdecf = wr_fire && aw_addr == `ICU_OFF_PDECF;
    wire wr_pdesc = wr_fire && aw_addr == `ICU_OFF_PDESC;
    assign wr_hit = mapped(aw_addr);
    assign rd_hit = mapped({s_axi_araddr[7:2], 2'b00});

    always_ff @(posedge clock) begin
        if (!rstn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= {s_axi_awaddr[7:2], 2'b00};
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ICU_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `ICU_RESP_OKAY : `ICU_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ICU_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `ICU_RESP_OKAY : `ICU_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Sensor frame tracking
    // ************************************************************
    logic [1:0] pins;
    logic pclk_d;
    logic vsync_q;
    icu_frame_t state;
    icu_frame_t next_state;
    icu_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .din({sensor_vsync, sensor_pclk}),
        .dout(pins)
    );
    wire pclk_rise = pins[0] && !pclk_d;
    wire vs_rise = pclk_rise && pins[1] && !vsync_q;
    wire vs_fall = pclk_rise && !pins[1] && vsync_q;

    logic [31:0] ctrl;
    logic pending;
    logic disabled;
    wire sync_err = sync_code_error && ctrl[`ICU_C_SYNCCORR];
    wire overrun = vs_rise && fifo.flushing;
    wire frame_go = vs_rise && !fifo.flushing && !ctrl[`ICU_C_DIS];

    // Frame state: skip on overrun or bad sync until next clean start
    always_comb begin
        next_state = state;
        case (state)
            FR_IDLE: begin
                if (overrun) begin
                    next_state = FR_SKIP;
                end else if (frame_go) begin
                    next_state = FR_ACTIVE;
                end
            end
            FR_ACTIVE: begin
                if (overrun || sync_err) begin
                    next_state = FR_SKIP;
                end else if (vs_fall) begin
                    next_state = FR_IDLE;
                end
            end
            FR_SKIP: begin
                if (frame_go) begin
                    next_state = FR_ACTIVE;
                end
            end
            default: next_state = FR_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn || soft_reset) begin
            state <= FR_IDLE;
            pclk_d <= 1'b0;
            vsync_q <= 1'b0;
        end else begin
            state <= next_state;
            pclk_d <= pins[0];
            vsync_q <= pclk_rise ? pins[1] : vsync_q;
        end
    end
    assign frame_discard = state == FR_SKIP;

    // ************************************************************
    // Control, codec request and setup registers
    // ************************************************************
    wire frame_start = frame_go && state != FR_ACTIVE;
    wire codec_req = wr_ctrl && wr_val[`ICU_C_CODEC];
    logic cemp_d;
    logic pemp_d;
    wire cemp_lvl = fifo.codec_empty && fifo.codec_dma_idle;
    wire pemp_lvl = fifo.preview_empty && fifo.preview_dma_idle;
    wire cemp_rise = cemp_lvl && !cemp_d;
    wire pemp_rise = pemp_lvl && !pemp_d;
    wire dis_now = ctrl[`ICU_C_DIS] && state != FR_ACTIVE;
    logic [31:0] psize;
    logic [7:0] pdecf;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctrl <= 32'h0000_0000;
            soft_reset <= 1'b0;
            psize <= `ICU_PSIZE_RST;
            pdecf <= `ICU_PDECF_RST;
            desc_base <= 32'h0000_0000;
            desc_load <= 1'b0;
            cemp_d <= 1'b1;
            pemp_d <= 1'b1;
            disabled <= 1'b0;
        end else begin
            ctrl <= wr_ctrl ? (wr_val & `ICU_CTRL_BITS) : ctrl;
            soft_reset <= wr_ctrl && wr_val[`ICU_C_SRST];
            psize <= wr_psize ? (merge(psize, w_data, w_strb) & `ICU_SIZE_BITS) : psize;
            pdecf <= wr_pdecf && w_strb[0] ? w_data[7:0] : pdecf;
            desc_base <= wr_pdesc ? (merge(desc_base, w_data, w_strb) & `ICU_DESC_ALIGN) : desc_base;
            desc_load <= wr_pdesc;
            cemp_d <= cemp_lvl;
            pemp_d <= pemp_lvl;
            disabled <= dis_now;
        end
    end

    // Pending until frame start, request wins
    always_ff @(posedge clock) begin
        if (!rstn || soft_reset) begin
            pending <= 1'b0;
            codec_active <= 1'b0;
            codec_capture_done <= 1'b0;
        end else begin
            pending <= codec_req || (pending && !frame_start);
            codec_active <= (frame_start && pending) || (codec_active && !cemp_rise);
            codec_capture_done <= codec_active && cemp_rise;
        end
    end

    assign preview.rows = psize[`ICU_ROWS_LSB +: 10];
    assign preview.cols = psize[`ICU_COLS_LSB +: 10];
    assign preview.decim = pdecf;
    assign preview.decim_on = pdecf > `ICU_DEC_MIN;

    // ************************************************************
    // Status flags, mask and interrupt
    // ************************************************************
    logic [9:0] status;
    logic [9:0] mask;
    logic [9:0] ev;
    always_comb begin
        ev = 10'h000;
        ev[`ICU_B_SOF] = vs_rise;
        ev[`ICU_B_DIS] = dis_now && !disabled;
        ev[`ICU_B_SRST] = soft_reset;
        ev[`ICU_B_SYNCERR] = sync_err;
        ev[`ICU_B_COVF] = fifo.codec_wr && fifo.codec_full;
        ev[`ICU_B_POVF] = fifo.preview_wr && fifo.preview_full;
        ev[`ICU_B_PEMP] = pemp_rise;
        ev[`ICU_B_CEMP] = cemp_rise;
        ev[`ICU_B_FOVR] = overrun;
    end
    wire [9:0] st_clr = wr_status ? wr_val[9:0] : 10'h000;
    wire [9:0] en_set = wr_en_set ? wr_val[9:0] : 10'h000;
    wire [9:0] en_clr = wr_en_clr ? wr_val[9:0] : 10'h000;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            status <= 10'h000;
            mask <= 10'h000;
        end else begin
            status <= ((status & ~st_clr) | ev) & `ICU_IRQ_BITS;
            mask <= ((mask | en_set) & ~en_clr) & `ICU_IRQ_BITS;
        end
    end
    assign irq = |(status & mask);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (s_axi_araddr & 8'hFC)
            `ICU_OFF_CTRL: rd_word = ctrl;
            `ICU_OFF_STATUS: rd_word = {22'h0, status | {6'h00, pending, 3'h0}};
            `ICU_OFF_IRQ_MASK: rd_word = {22'h0, mask};
            `ICU_OFF_PSIZE: rd_word = psize;
            `ICU_OFF_PDECF: rd_word = {24'h0, pdecf};
            `ICU_OFF_PDESC: rd_word = desc_current_valid ? (desc_current & `ICU_DESC_ALIGN) : desc_base;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence en_write;
        wr_en_set && wr_val[0];
    endsequence
    sequence mask_on;
        mask[0] ##1 mask[0];
    endsequence
    irq_level_a: assert property (|(ev & mask & ~en_clr) |=> irq) else $error("unmasked event no irq");
    mask_set_a: assert property (en_write |=> mask_on or (mask[0] ##0 wr_en_clr)) else $error("enable lost");
    mask_clr_a: assert property (wr_en_clr && wr_val[0] |=> !mask[0]) else $error("disable lost");
    mask_zero_a: assert property (wr_en_set && wr_val == 32'h0 |=> mask == $past(mask)) else $error("zero changed");
    bit3_free_a: assert property (!mask[3] && !status[3]) else $error("bit 3 used");
    covf_set_a: assert property (fifo.codec_wr && fifo.codec_full |=> status[`ICU_B_COVF]) else $error("no covf");
    povf_set_a: assert property (fifo.preview_wr && fifo.preview_full |=> status[`ICU_B_POVF]) else $error("no povf");
    pend_hold_a: assert property (pending && !frame_start && !soft_reset |=> pending) else $error("pending drop");
    sync_skip_a: assert property (sync_err && state == FR_ACTIVE && !soft_reset |=> frame_discard [*1]
        ##0 status[`ICU_B_SYNCERR]) else $error("sync error kept frame");
    ovr_skip_a: assert property (overrun && !soft_reset |=> frame_discard && status[`ICU_B_FOVR])
        else $error("overrun not skipped");
    dec_off_a: assert property (pdecf <= 8'h10 |-> !preview.decim_on) else $error("decimation on");
    desc_align_a: assert property (desc_base[1:0] == 2'b00) else $error("pointer unaligned");
endmodule

// [icu_defs.svh]
// Register offsets, field positions, reset values and limits of the image capture status block
`ifndef ICU_DEFS_SVH
`define ICU_DEFS_SVH
`define ICU_OFF_CTRL 8'h00
`define ICU_OFF_STATUS 8'h0C
`define ICU_OFF_IRQ_EN_SET 8'h10
`define ICU_OFF_IRQ_EN_CLR 8'h14
`define ICU_OFF_IRQ_MASK 8'h18
`define ICU_OFF_PSIZE 8'h20
`define ICU_OFF_PDECF 8'h24
`define ICU_OFF_PDESC 8'h28
`define ICU_B_SOF 0
`define ICU_B_DIS 1
`define ICU_B_SRST 2
`define ICU_B_PEND 3
`define ICU_B_SYNCERR 4
`define ICU_B_COVF 5
`define ICU_B_POVF 6
`define ICU_B_PEMP 7
`define ICU_B_CEMP 8
`define ICU_B_FOVR 9
`define ICU_IRQ_BITS 10'h3F7
`define ICU_C_SRST 0
`define ICU_C_DIS 1
`define ICU_C_SYNCCORR 7
`define ICU_C_CODEC 15
`define ICU_CTRL_BITS 32'h0000_0082
`define ICU_ROWS_LSB 0
`define ICU_COLS_LSB 16
`define ICU_SIZE_BITS 32'h03FF_03FF
`define ICU_PSIZE_RST 32'h0000_0000
`define ICU_PDECF_RST 8'h10
`define ICU_DEC_MIN 8'h10
`define ICU_DESC_ALIGN 32'hFFFF_FFFC
`define ICU_RESP_OKAY 2'h0
`define ICU_RESP_SLVERR 2'h2
`endif

// [icu_pkg.sv]
// Types shared by the image capture status block
package icu_pkg;
    typedef struct packed {
        logic codec_wr;
        logic codec_full;
        logic codec_empty;
        logic codec_dma_idle;
        logic preview_wr;
        logic preview_full;
        logic preview_empty;
        logic preview_dma_idle;
        logic flushing;
    } icu_fifo_t;
    typedef struct packed {
        logic [9:0] rows;
        logic [9:0] cols;
        logic [7:0] decim;
        logic decim_on;
    } icu_prev_t;
    typedef enum logic [2:0] {
        FR_IDLE = 3'b001,
        FR_ACTIVE = 3'b010,
        FR_SKIP = 3'b100
    } icu_frame_t;
endpackage

// [icu_sync.sv]
// Two-flop synchroniser for the sensor pins
`timescale 1ns/10ps
module icu_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Pins in, synchronised out
    input wire logic [1:0] din,
    output logic [1:0] dout
);
    logic [1:0] meta;
    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta <= 2'h0;
            dout <= 2'h0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

// [icu_sensor_model.sv]
// Behavioural image sensor driving pixel clock and vertical sync
`timescale 1ns/10ps
module icu_sensor_model (
    // Sensor pins
    output logic pclk,
    output logic vsync
);
    logic running;
    // Clock stands low outside frame edges, phase unrelated to system clock
    initial begin
        pclk = 1'b0;
        vsync = 1'b0;
        running = 1'b0;
        #7;
        forever begin
            #80;
            pclk = running ? ~pclk : 1'b0;
        end
    end
    task automatic set_vsync(input logic level);
        running = 1'b1;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        vsync = level;
        repeat (4) @(posedge pclk);
        running = 1'b0;
    endtask
endmodule

// [tb_icu_top.sv]
// Self-checking bench for the image capture status and interrupt block
`timescale 1ns/10ps
`include "icu_defs.svh"
module tb_icu_top;
    import icu_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r; logic [1:0] resp;} icu_reg_row_t;
    typedef struct {logic [8:0] v; logic [9:0] flag;} icu_evt_row_t;
    logic clock, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sync_code_error, desc_current_valid, seen;
    logic desc_load, frame_discard, codec_active, codec_capture_done, soft_reset, irq;
    logic sensor_pclk, sensor_vsync;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, desc_current, desc_base, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    logic [7:0] dec_vals[3] = '{8'h10, 8'h00, 8'hFF};
    icu_fifo_t fifo;
    icu_prev_t preview;
    icu_reg_row_t regs[5];
    icu_evt_row_t evts[5];
    int errors, checked;

    icu_top i_icu_top (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sensor_pclk(sensor_pclk),
        .sensor_vsync(sensor_vsync), .fifo(fifo), .sync_code_error(sync_code_error),
        .desc_current(desc_current), .desc_current_valid(desc_current_valid), .preview(preview),
        .desc_base(desc_base), .desc_load(desc_load), .frame_discard(frame_discard),
        .codec_active(codec_active), .codec_capture_done(codec_capture_done), .soft_reset(soft_reset),
        .irq(irq));
    icu_sensor_model i_icu_sensor_model (.pclk(sensor_pclk), .vsync(sensor_vsync));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ********
    // Bus and check tasks
    // ********
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic hung();
        errors++;
        $display("MISMATCH at %0t: no answer", $time);
        conclude();
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic got;
        got = 1'b0;
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100 && !got; n++) begin
            @(posedge clock);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1'b1;
                resp = bresp;
                bready <= 1'b0;
            end
        end
        if (!got) hung();
    endtask
    task automatic axi_read(input logic [7:0] a);
        logic got;
        got = 1'b0;
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100 && !got; n++) begin
            @(posedge clock);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got = 1'b1;
                rd = rdata;
                resp = rresp;
                rready <= 1'b0;
            end
        end
        if (!got) hung();
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        axi_read(a);
        check(rd & mask, exp, "register read");
    endtask
    task automatic fifo_pulse(input logic [8:0] v);
        @(posedge clock);
        fifo <= icu_fifo_t'(v);
        @(posedge clock);
        fifo <= icu_fifo_t'(v & 9'h0EF);
    endtask
    task automatic vsync(input logic level);
        i_icu_sensor_model.set_vsync(level);
        @(posedge clock);
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, sync_code_error, desc_current_valid} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hF;
        desc_current = '0;
        fifo = '0;
        errors = 0;
        checked = 0;
        regs[0] = '{`ICU_OFF_PSIZE, 32'hFE7F_FDDF, 32'h027F_01DF, `ICU_RESP_OKAY};
        regs[1] = '{`ICU_OFF_PDECF, 32'hFFFF_FF11, 32'h0000_0011, `ICU_RESP_OKAY};
        regs[2] = '{`ICU_OFF_PDESC, 32'h1234_5677, 32'h1234_5674, `ICU_RESP_OKAY};
        regs[3] = '{`ICU_OFF_IRQ_EN_SET, 32'hFFFF_FFFF, 32'h0000_0000, `ICU_RESP_OKAY};
        regs[4] = '{8'h40, 32'hFFFF_FFFF, 32'h0000_0000, `ICU_RESP_SLVERR};
        evts[0] = '{9'h100, 10'h000};
        evts[1] = '{9'h180, 10'h020};
        evts[2] = '{9'h018, 10'h040};
        evts[3] = '{9'h004, 10'h000};
        evts[4] = '{9'h006, 10'h080};
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        // Reset values
        check({31'h0, preview.decim_on}, 32'h0, "decimation off");
        rd_check(`ICU_OFF_PDECF, 32'hFFFF_FFFF, 32'h0000_0010);
        rd_check(`ICU_OFF_PSIZE, 32'hFFFF_FFFF, 32'h0);
        rd_check(`ICU_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0);
        rd_check(`ICU_OFF_PDESC, 32'hFFFF_FFFF, 32'h0);
        foreach (regs[i]) begin
            axi_write(regs[i].a, regs[i].w);
            check(resp, regs[i].resp, "write response");
            check({31'h0, desc_load}, {31'h0, regs[i].a == `ICU_OFF_PDESC}, "pointer load");
            axi_read(regs[i].a);
            check(rd, regs[i].r, "read back");
            check(resp, regs[i].resp, "read response");
        end
        check({22'h0, preview.rows}, 32'h1DF, "rows");
        check({22'h0, preview.cols}, 32'h27F, "cols");
        check(desc_base, 32'h1234_5674, "pointer out");
        desc_current_valid <= 1'b1;
        desc_current <= 32'hAAAA_5557;
        rd_check(`ICU_OFF_PDESC, 32'hFFFF_FFFF, 32'hAAAA_5554);
        foreach (dec_vals[i]) begin
            axi_write(`ICU_OFF_PDECF, {24'h0, dec_vals[i]});
            check({31'h0, preview.decim_on}, {31'h0, dec_vals[i] > 8'h10}, "decimation");
            check({24'h0, preview.decim}, {24'h0, dec_vals[i]}, "decimation field");
        end
        // Mask set and clear
        rd_check(`ICU_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_03F7);
        axi_write(`ICU_OFF_IRQ_EN_CLR, 32'h0000_0001);
        rd_check(`ICU_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_03F6);
        axi_write(`ICU_OFF_IRQ_EN_SET, 32'h0);
        axi_write(`ICU_OFF_IRQ_EN_CLR, 32'h0);
        rd_check(`ICU_OFF_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_03F6);
        axi_write(`ICU_OFF_CTRL, 32'h0000_0080);
        axi_write(`ICU_OFF_STATUS, 32'h0000_03FF);
        check({31'h0, irq}, 32'h0, "irq idle");
        // FIFO events
        foreach (evts[i]) begin
            fifo_pulse(evts[i].v);
            rd_check(`ICU_OFF_STATUS, 32'h0000_03F0, {22'h0, evts[i].flag});
            check({31'h0, irq}, {31'h0, |evts[i].flag}, "irq raised");
            axi_write(`ICU_OFF_STATUS, {22'h0, evts[i].flag});
            check({31'h0, irq}, 32'h0, "irq cleared");
        end
        // Frames from the sensor
        axi_write(`ICU_OFF_CTRL, 32'h0000_8080);
        rd_check(`ICU_OFF_STATUS, 32'h0000_0009, 32'h0000_0008);
        fifo <= '0;
        vsync(1'b1);
        rd_check(`ICU_OFF_STATUS, 32'h0000_0009, 32'h0000_0001);
        check({30'h0, codec_active, irq}, 32'h2, "active, start masked");
        fifo <= icu_fifo_t'(9'h060);
        seen = 1'b0;
        for (int n = 0; n < 20 && !seen; n++) begin
            @(posedge clock);
            seen = (codec_capture_done === 1'b1);
        end
        check({30'h0, seen, codec_active}, 32'h2, "capture done");
        if (!seen) hung();
        rd_check(`ICU_OFF_STATUS, 32'h0000_0100, 32'h0000_0100);
        axi_write(`ICU_OFF_STATUS, 32'h0000_03FF);
        @(posedge clock);
        sync_code_error <= 1'b1;
        @(posedge clock);
        sync_code_error <= 1'b0;
        @(posedge clock);
        check({31'h0, frame_discard}, 32'h1, "frame discarded");
        rd_check(`ICU_OFF_STATUS, 32'h0000_0010, 32'h0000_0010);
        vsync(1'b0);
        vsync(1'b1);
        check({31'h0, frame_discard}, 32'h0, "next frame taken");
        vsync(1'b0);
        fifo <= icu_fifo_t'(9'h061);
        vsync(1'b1);
        check({31'h0, frame_discard}, 32'h1, "frame skipped");
        rd_check(`ICU_OFF_STATUS, 32'h0000_0200, 32'h0000_0200);
        axi_write(`ICU_OFF_CTRL, 32'h0000_0081);
        check({31'h0, soft_reset}, 32'h1, "soft reset pulse");
        rd_check(`ICU_OFF_STATUS, 32'h0000_0004, 32'h0000_0004);
        check({31'h0, frame_discard}, 32'h0, "soft reset clears skip");
        axi_write(`ICU_OFF_CTRL, 32'h0000_0082);
        rd_check(`ICU_OFF_STATUS, 32'h0000_0002, 32'h0000_0002);
        conclude();
    end
endmodule
